// *** hdl/dsadc_ctrl.sv ***
// conversion control for a dual 14-bit sar converter with a serial read port
// assumes pins arrive asynchronous to core_clk; comparators on core_clk
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`include "dsadc_consts.svh"
module dsadc_ctrl
    import dsadc_pkg::*;
#(
    parameter int BITS = `DSADC_RES_BITS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic conv_start_n, // pin
    input wire logic chan_select, // pin
    input wire logic reference_source_strap, // pin
    input wire logic span_select_lo, // pin
    input wire logic span_select_hi, // pin
    input wire logic chip_select_n, // pin
    input wire logic serial_clk, // pin, host clock
    input wire logic cmp_a_high, // comparator a
    input wire logic cmp_b_high, // comparator b
    output logic busy,
    output logic hold, // track-and-hold in hold
    output logic power_down,
    output logic internal_ref,
    output logic chan_pair,
    output logic [1:0] span_code,
    output logic [BITS-1:0] dac_a,
    output logic [BITS-1:0] dac_b,
    output logic result_line_a,
    output logic result_line_a_oe,
    output logic result_line_b,
    output logic result_line_b_oe,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq
);
    // elaboration check: the frame counter and register layout assume 14 bits
    if (BITS != `DSADC_RES_BITS) begin : g_bits_check
        $error("dsadc_ctrl: only 14-bit supported");
    end

    // two-flop synchronisers for every pin
    logic [6:0] pin_m, pin_s, pin_d;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pin_m <= 7'h7f;
            pin_s <= 7'h7f;
            pin_d <= 7'h7f;
        end else begin
            pin_m <= {conv_start_n, chan_select, reference_source_strap, span_select_lo,
                span_select_hi, chip_select_n, serial_clk};
            pin_s <= pin_m;
            pin_d <= pin_s;
        end
    end
    logic cs_n_s, sclk_s, conv_n_s;
    assign conv_n_s = pin_s[6];
    assign cs_n_s = pin_s[1];
    assign sclk_s = pin_s[0];
    logic conv_fall, conv_rise, sclk_fall;
    assign conv_fall = pin_d[6] && !pin_s[6];
    assign conv_rise = !pin_d[6] && pin_s[6];
    assign sclk_fall = pin_d[0] && !sclk_s;

    // software enable from the control register
    logic ctrl_en;

    // internal conversion oscillator, independent of the host clock
    logic [`DSADC_OSC_W-1:0] osc_cnt;
    logic osc_tick;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            osc_cnt <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= (osc_cnt == `DSADC_OSC_DIV - 4'h1);
            osc_cnt <= (osc_cnt == `DSADC_OSC_DIV - 4'h1) ? '0 : osc_cnt + 4'h1;
        end
    end

    dsadc_state_t state;
    logic start_pulse, done_a, done_b, got_a, got_b;
    logic [BITS-1:0] res_a, res_b;

    // sequencer: start, run, end-of-conversion and power-down
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= DSADC_IDLE;
            start_pulse <= 1'b0;
            busy <= 1'b0;
            hold <= 1'b0;
            power_down <= 1'b0;
            got_a <= 1'b0;
            got_b <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            case (state)
                DSADC_IDLE: begin
                    // only the start pin controls power; a start also needs ctrl_en set
                    if (conv_fall && ctrl_en) begin
                        hold <= 1'b1;
                        start_pulse <= 1'b1; // both engines start together
                        busy <= 1'b1;
                        got_a <= 1'b0;
                        got_b <= 1'b0;
                        state <= DSADC_CONV;
                    end
                end
                DSADC_CONV: begin
                    if (done_a) got_a <= 1'b1;
                    if (done_b) got_b <= 1'b1;
                    if ((got_a || done_a) && (got_b || done_b)) state <= DSADC_DONE;
                end
                DSADC_DONE: begin
                    busy <= 1'b0;
                    hold <= 1'b0; // track again at busy fall
                    if (!conv_n_s) begin
                        power_down <= 1'b1;
                        state <= DSADC_PDOWN;
                    end else begin
                        state <= DSADC_IDLE;
                    end
                end
                DSADC_PDOWN: begin
                    if (conv_rise) begin
                        power_down <= 1'b0; // rising edge wakes the core
                        state <= DSADC_IDLE;
                    end
                end
                default: state <= DSADC_IDLE;
            endcase
        end
    end

    // channel pair latched at busy rise for the following conversion
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            chan_pair <= 1'b0; // first pair by default
        end else if (start_pulse) begin
            chan_pair <= pin_s[5];
        end
    end

    // straps and span followed only while idle so they stay put during a run
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            internal_ref <= 1'b0;
            span_code <= 2'h0;
        end else if (state == DSADC_IDLE) begin
            internal_ref <= pin_s[4]; // high selects internal for both
            span_code <= {pin_s[2], pin_s[3]};
        end
    end

    // two engines clocked by the same oscillator enable
    dsadc_sar #(.BITS(BITS)) u_sar_a (
        .core_clk(core_clk), .nrst(nrst), .start(start_pulse), .osc_tick(osc_tick),
        .cmp_high(cmp_a_high), .trial(dac_a), .result(res_a), .done(done_a));
    dsadc_sar #(.BITS(BITS)) u_sar_b (
        .core_clk(core_clk), .nrst(nrst), .start(start_pulse), .osc_tick(osc_tick),
        .cmp_high(cmp_b_high), .trial(dac_b), .result(res_b), .done(done_b));

    // output shift registers: a then b on line a, b then a on line b
    logic [2*BITS-1:0] shift_a, shift_b;
    logic [`DSADC_CNT_W-1:0] bit_cnt;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            shift_a <= '0;
            shift_b <= '0;
            bit_cnt <= '0;
            result_line_a <= 1'b0;
            result_line_b <= 1'b0;
            result_line_a_oe <= 1'b0;
            result_line_b_oe <= 1'b0;
        end else begin
            // load once both results exist; held until next completion
            if (state == DSADC_DONE) begin
                shift_a <= {res_a, res_b};
                shift_b <= {res_b, res_a};
                bit_cnt <= '0;
            end else if (cs_n_s) begin
                bit_cnt <= '0;
            end else if (sclk_fall && !busy && bit_cnt != `DSADC_READ_CLKS) begin
                // advance on host clock only after conversion
                shift_a <= {shift_a[2*BITS-2:0], 1'b0};
                shift_b <= {shift_b[2*BITS-2:0], 1'b0};
                bit_cnt <= bit_cnt + 5'h1; // stops after 28
            end
            result_line_a <= shift_a[2*BITS-1]; // msb first
            result_line_b <= shift_b[2*BITS-1];
            // drive until chip select rises, not after last clock
            result_line_a_oe <= !cs_n_s;
            result_line_b_oe <= !cs_n_s;
        end
    end

    // interrupt status, set-wins-over-clear, write one to clear
    logic [`DSADC_IRQ_W-1:0] irq_stat, irq_mask, irq_set;
    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_comb begin
        irq_set = '0;
        irq_set[`DSADC_IRQ_EOC] = (state == DSADC_DONE);
        irq_set[`DSADC_IRQ_PD] = (state == DSADC_DONE) && !conv_n_s;
        irq_set[`DSADC_IRQ_BADSPAN] = start_pulse && (span_code == `DSADC_SPAN_BAD);
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_stat <= '0;
        end else begin
            if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i[3:0] == `DSADC_ADDR_IRQ) begin
                irq_stat <= (irq_stat & ~wb_dat_i[`DSADC_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // wishbone classic slave: ack one cycle after request, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl_en <= 1'b1;
            irq_mask <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= '0;
            if (wb_hit) begin
                if (wb_adr_i[3:0] == `DSADC_ADDR_CTRL) begin
                    if (wb_we_i && wb_sel_i[0]) ctrl_en <= wb_dat_i[`DSADC_CTRL_EN];
                    wb_dat_o <= {31'h0, ctrl_en};
                end else if (wb_adr_i[3:0] == `DSADC_ADDR_STAT) begin
                    wb_dat_o <= {26'h0, span_code, internal_ref, chan_pair, power_down, busy};
                end else if (wb_adr_i[3:0] == `DSADC_ADDR_IRQ) begin
                    wb_dat_o <= {29'h0, irq_stat};
                end else if (wb_adr_i[3:0] == `DSADC_ADDR_MASK) begin
                    if (wb_we_i && wb_sel_i[0]) irq_mask <= wb_dat_i[`DSADC_IRQ_W-1:0];
                    wb_dat_o <= {29'h0, irq_mask};
                end
            end
        end
    end
endmodule : dsadc_ctrl

// *** hdl/dsadc_consts.svh ***
// constants for the dual sar conversion control block
// assumes inclusion by bare name from the package and the design modules
`ifndef DSADC_CONSTS_SVH
`define DSADC_CONSTS_SVH
`define DSADC_RES_BITS 14
`define DSADC_CNT_W 5
`define DSADC_READ_CLKS 5'h1c
`define DSADC_OSC_DIV 4'h4
`define DSADC_OSC_W 4
// wishbone register byte addresses
`define DSADC_ADDR_CTRL 4'h0
`define DSADC_ADDR_STAT 4'h4
`define DSADC_ADDR_IRQ 4'h8
`define DSADC_ADDR_MASK 4'hc
// status / irq bit positions
`define DSADC_IRQ_EOC 0
`define DSADC_IRQ_PD 1
`define DSADC_IRQ_BADSPAN 2
`define DSADC_IRQ_W 3
// control bit positions and the forbidden span code
`define DSADC_CTRL_EN 0
`define DSADC_SPAN_BAD 2'h3
`endif

// *** hdl/dsadc_pkg.sv ***
// types shared by the conversion control block
// assumes the constants header is on the include path
`include "dsadc_consts.svh"
package dsadc_pkg;
    // conversion sequencer states
    typedef enum logic [2:0] {
        DSADC_IDLE,
        DSADC_CONV,
        DSADC_DONE,
        DSADC_PDOWN
    } dsadc_state_t;
endpackage : dsadc_pkg

// *** hdl/dsadc_sar.sv ***
// one successive approximation search engine
// assumes a one-cycle oscillator enable and a comparator input on the same clock
`timescale 1ns/1ns
`include "dsadc_consts.svh"
module dsadc_sar
    import dsadc_pkg::*;
#(
    parameter int BITS = `DSADC_RES_BITS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start, // one-cycle pulse, begins a search
    input wire logic osc_tick, // internal oscillator enable
    input wire logic cmp_high, // comparator: sample above trial level
    output logic [BITS-1:0] trial, // dac trial code
    output logic [BITS-1:0] result,
    output logic done // one-cycle pulse at completion
);
    // elaboration check: a search needs at least a sign bit and one more
    if (BITS < 2) begin : g_bits_check
        $error("dsadc_sar: resolution too small");
    end

    logic [BITS-1:0] bit_mask; // current bit under test, walks msb to lsb
    logic running;

    // binary search: keep each trial bit while the comparator still says higher
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            trial <= '0;
            bit_mask <= '0;
            running <= 1'b0;
            done <= 1'b0;
            result <= '0;
        end else begin
            done <= 1'b0;
            if (start) begin
                trial <= {1'b1, {(BITS-1){1'b0}}};
                bit_mask <= {1'b1, {(BITS-1){1'b0}}};
                running <= 1'b1;
            end else if (running && osc_tick) begin
                // charge balanced when the last bit is decided
                if (bit_mask[0]) begin
                    running <= 1'b0;
                    done <= 1'b1;
                    // offset-binary search to two's complement output code
                    result <= (cmp_high ? trial : (trial & ~bit_mask))
                        ^ {1'b1, {(BITS-1){1'b0}}};
                end else begin
                    trial <= (cmp_high ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
                end
                bit_mask <= bit_mask >> 1;
            end
        end
    end
endmodule : dsadc_sar

// *** tb/dsadc_ctrl_sva.sv ***
// checker: port-level timing of the conversion control block
// assumes it is bound onto dsadc_ctrl; everything runs on core_clk
`timescale 1ns/1ns
module dsadc_ctrl_sva #(
    parameter int BITS = 14
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic conv_start_n,
    input wire logic chan_select,
    input wire logic chip_select_n,
    input wire logic busy,
    input wire logic hold,
    input wire logic power_down,
    input wire logic internal_ref,
    input wire logic chan_pair,
    input wire logic [1:0] span_code,
    input wire logic result_line_a_oe,
    input wire logic result_line_b_oe
);
    logic [7:0] busy_cnt; // cycles busy has stood high so far
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // length of the running conversion; busy is low in reset, so it clears there
    always_ff @(posedge core_clk) begin
        busy_cnt <= busy ? busy_cnt + 8'h1 : 8'h0;
    end
    property p_start;
        $rose(busy) |-> $past(conv_start_n, 5) && !$past(conv_start_n);
    endproperty
    a_start: assert property (p_start)
        else $error("busy rose without a start edge");
    property p_hold;
        hold == busy;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold does not follow busy");
    // one oscillator tick every four cycles per result bit, some slack at the end
    property p_length;
        $fell(busy) |-> busy_cnt >= BITS * 4 - 4 && busy_cnt <= BITS * 4 + 40;
    endproperty
    a_length: assert property (p_length)
        else $error("conversion length out of range");
    property p_pd_in;
        $fell(busy) && !conv_start_n |-> ##[0:3] power_down;
    endproperty
    a_pd_in: assert property (p_pd_in)
        else $error("no power-down with start low at end");
    property p_no_pd;
        $fell(busy) && conv_start_n |-> !power_down [*4];
    endproperty
    a_no_pd: assert property (p_no_pd)
        else $error("power-down with start high");
    property p_wake;
        power_down && $rose(conv_start_n) |-> ##[1:6] !power_down;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on start rise");
    property p_release;
        $rose(chip_select_n) |-> ##[1:5] !result_line_a_oe && !result_line_b_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("lines still driven after select high");
    property p_pair_oe;
        result_line_a_oe == result_line_b_oe;
    endproperty
    a_pair_oe: assert property (p_pair_oe)
        else $error("data lines enabled apart");
    property p_chan;
        $changed(chan_pair) |-> busy && chan_pair == chan_select;
    endproperty
    a_chan: assert property (p_chan)
        else $error("pair select changed outside busy rise");
    // straps may settle at the busy rise edge, so look two cycles in
    property p_straps;
        busy && $past(busy, 2) |-> $stable({internal_ref, span_code});
    endproperty
    a_straps: assert property (p_straps)
        else $error("straps moved during conversion");
    c_conv: cover property ($fell(busy));
    c_pd: cover property ($rose(power_down));
    c_read: cover property ($rose(result_line_a_oe));
endmodule : dsadc_ctrl_sva

bind dsadc_ctrl dsadc_ctrl_sva #(.BITS(BITS)) i_sva (.core_clk, .nrst, .conv_start_n,
    .chan_select, .chip_select_n, .busy, .hold, .power_down, .internal_ref, .chan_pair,
    .span_code, .result_line_a_oe, .result_line_b_oe);

// *** tb/dsadc_host.sv ***
// host model: drives conversion start, chip select and the serial clock
// assumes the block's busy and result lines; serial clock idles high
`timescale 1ns/1ns
module dsadc_host (
    input wire logic core_clk,
    input wire logic busy,
    input wire logic result_line_a,
    input wire logic result_line_a_oe,
    input wire logic result_line_b,
    input wire logic result_line_b_oe,
    output logic conv_start_n,
    output logic chip_select_n,
    output logic serial_clk
);
    logic last_a = 1'b0; // last level seen on line a
    logic last_b = 1'b0; // last level seen on line b
    logic seen_a;
    logic seen_b;
    // a released line shows the inverse of its last level, never a stale copy
    assign seen_a = result_line_a_oe ? result_line_a : ~last_a;
    assign seen_b = result_line_b_oe ? result_line_b : ~last_b;
    always @(posedge core_clk) begin
        last_a <= seen_a;
        last_b <= seen_b;
    end
    initial begin
        conv_start_n = 1'b1;
        chip_select_n = 1'b1;
        serial_clk = 1'b1;
    end
    // start edge; stay_low keeps start low past the end to power down
    task automatic convert(input logic stay_low);
        int n;
        @(posedge core_clk);
        conv_start_n <= 1'b0;
        for (n = 0; n < 20 && !busy; n++) @(posedge core_clk);
        if (!stay_low) conv_start_n <= 1'b1;
        for (n = 0; n < 200 && busy; n++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
    endtask : convert
    // rising start edge brings the block out of power-down
    task automatic wake();
        @(posedge core_clk);
        conv_start_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask : wake
    // framed read after conversion, bit taken just before each falling clock
    task automatic read_frame(output logic [27:0] fa, output logic [27:0] fb);
        @(posedge core_clk);
        chip_select_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        // periods of 12 and 13 core cycles alternate, 125 ns on average
        for (int k = 27; k >= 0; k--) begin
            @(posedge core_clk);
            fa[k] = seen_a;
            fb[k] = seen_b;
            serial_clk <= 1'b0;
            repeat (6) @(posedge core_clk);
            serial_clk <= 1'b1;
            repeat (5 + k % 2) @(posedge core_clk);
        end
        @(posedge core_clk);
        chip_select_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask : read_frame
endmodule : dsadc_host

// *** tb/testbench.sv ***
// self-checking bench for the dual sar conversion control block
// assumes the host model and the bound checker from tb/
`timescale 1ns/1ns
module testbench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic chan_select = 1'b0;
    logic reference_source_strap = 1'b1;
    logic span_select_lo = 1'b0;
    logic span_select_hi = 1'b0;
    logic [13:0] samp_a = 14'h0; // analog levels as offset-binary codes
    logic [13:0] samp_b = 14'h0;
    logic [13:0] sa [3] = '{14'h0, 14'h3fff, 14'h2000};
    logic [13:0] sb [3] = '{14'h3fff, 14'h1555, 14'h1};
    logic conv_start_n, chip_select_n, serial_clk, busy, hold, power_down;
    logic internal_ref, chan_pair, irq, wb_ack_o;
    logic result_line_a, result_line_a_oe, result_line_b, result_line_b_oe;
    logic [1:0] span_code;
    logic [13:0] dac_a, dac_b;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [27:0] fa, fb;
    int n_fail = 0, compares = 0, cycles = 0;
    // comparators: sample at or above the trial code
    wire cmp_a_high = samp_a >= dac_a;
    wire cmp_b_high = samp_b >= dac_b;
    always #5 core_clk = ~core_clk;
    dsadc_ctrl i_dut (.core_clk, .nrst, .conv_start_n, .chan_select, .reference_source_strap,
        .span_select_lo, .span_select_hi, .chip_select_n, .serial_clk, .cmp_a_high,
        .cmp_b_high, .busy, .hold, .power_down, .internal_ref, .chan_pair, .span_code,
        .dac_a, .dac_b, .result_line_a, .result_line_a_oe, .result_line_b,
        .result_line_b_oe, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq);
    dsadc_host i_host (.core_clk, .busy, .result_line_a, .result_line_a_oe,
        .result_line_b, .result_line_b_oe, .conv_start_n, .chip_select_n, .serial_clk);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // classic cycle: request held until ack is sampled, read data taken there
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        // no cycle count assumed: only the hang guard ends this wait
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) @(posedge core_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : wb
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // hang guard: the whole run needs under two thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        wb(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h1);
        // the decoder looks at the low address bits only, so read a real register
        wb(1'b0, 32'h8, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 32'hc, 32'h1);
        // each legal span code, alternating pair select and reference strap
        for (int i = 0; i < 3; i++) begin
            chan_select <= i[0];
            reference_source_strap <= (i != 1);
            {span_select_hi, span_select_lo} <= i[1:0];
            samp_a <= sa[i];
            samp_b <= sb[i];
            i_host.convert(1'b0);
            chk(irq, 1'b1);
            wb(1'b0, 32'h4, 32'h0);
            chk(rd, {26'h0, i[1:0], reference_source_strap, i[0], 2'b00});
            i_host.read_frame(fa, fb);
            chk(fa, {sa[i] ^ 14'h2000, sb[i] ^ 14'h2000});
            chk(fb, {sb[i] ^ 14'h2000, sa[i] ^ 14'h2000});
            wb(1'b1, 32'h8, 32'h7);
            chk(irq, 1'b0);
        end
        // the forbidden span code is flagged only when a conversion starts with it
        {span_select_hi, span_select_lo} <= 2'b11;
        repeat (8) @(posedge core_clk);
        i_host.convert(1'b0);
        wb(1'b0, 32'h8, 32'h0);
        chk(rd & 32'h4, 32'h4);
        // clear end-of-conversion: the masked span flag alone must not interrupt
        wb(1'b1, 32'h8, 32'h1);
        chk(irq, 1'b0);
        {span_select_hi, span_select_lo} <= 2'b00;
        wb(1'b1, 32'h8, 32'h4);
        i_host.convert(1'b1);
        chk(power_down, 1'b1);
        wb(1'b0, 32'h8, 32'h0);
        chk(rd & 32'h2, 32'h2);
        i_host.wake();
        chk(power_down, 1'b0);
        wb(1'b1, 32'h8, 32'h7);
        i_host.convert(1'b0);
        chk(irq, 1'b1);
        stop_test();
    end
endmodule : testbench
